// ---- ldrd_regs.vh ----
`ifndef LDRD_REGS_VH
`define LDRD_REGS_VH
// =====================================================
// Register indexes; byte address is four times the index
`define LDRD_IDX_DUTY 8'h93
`define LDRD_IDX_RAMP 8'h94
`define LDRD_IDX_DELAY 8'h95
`define LDRD_IDX_MODE 8'h98
`define LDRD_IDX_SENSE 8'h9c
`define LDRD_IDX_STATUS 8'ha0
// Byte addresses seen on the bus, one word per register
`define LDRD_ADDR_DUTY {`LDRD_IDX_DUTY, 2'h0}
`define LDRD_ADDR_RAMP {`LDRD_IDX_RAMP, 2'h0}
`define LDRD_ADDR_DELAY {`LDRD_IDX_DELAY, 2'h0}
`define LDRD_ADDR_MODE {`LDRD_IDX_MODE, 2'h0}
`define LDRD_ADDR_SENSE {`LDRD_IDX_SENSE, 2'h0}
`define LDRD_ADDR_STATUS {`LDRD_IDX_STATUS, 2'h0}
// =====================================================
// Reset values
`define LDRD_RST_DUTY 8'hf0
`define LDRD_RST_RAMP 8'h00
`define LDRD_RST_DELAY 8'h00
// =====================================================
// Field positions
`define LDRD_RISE_HI 5
`define LDRD_RISE_LO 3
`define LDRD_FALL_HI 2
`define LDRD_FALL_LO 0
`define LDRD_DLY_HI 2
`define LDRD_DLY_LO 0
`define LDRD_PEAK_HI 7
`define LDRD_PEAK_LO 4
`define LDRD_FLOOR_HI 3
`define LDRD_FLOOR_LO 0
// =====================================================
// Timing
`define LDRD_TICK_MS 1
`define LDRD_CLK_KHZ 40000
`define LDRD_TICK_CYCLES (`LDRD_TICK_MS * `LDRD_CLK_KHZ)
`define LDRD_PWM_STEPS 100
`define LDRD_DUTY_FULL 16'd10000
`define LDRD_BP_STEP 16'h0064
// =====================================================
// Per-LED states
`define LDRD_ST_IDLE 2'h0
`define LDRD_ST_RISE 2'h1
`define LDRD_ST_HOLD 2'h2
`define LDRD_ST_DELAY 2'h3
`endif

// ---- ldrd_top.v ----
`timescale 1ns/1ps
`default_nettype none
`include "ldrd_regs.vh"
// Notes on behaviour
// R01 - Ramp timing applies only to Direct LEDs
// R02 - Rise field bits 5:3 select rise time
// R03 - Fall field bits 2:0 select fall time
// R04 - Codes decode 0 to 2 s ramp
// R05 - Software copies fall code into rise field
// R06 - Released LED stays active for off delay
// R07 - Shared off delay field bits 2:0
// R08 - Off delay codes decode 0 to 5 s
// R09 - Sense bit 1 non-inverted, 0 inverted
// R10 - Duty register holds peak and floor nibbles
// R11 - Duty changes take effect immediately
// R12 - Rise, hold, delay, fall; reactuation restarts rise
// R13 - Slow tick sets ramp and delay timing
module ldrd_top #(
  parameter NLED = 11,
  parameter TICK_CYCLES = `LDRD_TICK_CYCLES
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire [NLED-1:0] led_actuate,
  output reg [NLED-1:0] led_drive
);
  // =====================================================
  // Register file
  reg [7:0] duty_ff;          // Peak/floor nibbles
  reg [7:0] ramp_ff;          // Rise and fall codes
  reg [2:0] delay_ff;         // Shared release hold code
  reg [NLED-1:0] mode_ff;     // 1 = Direct behaviour
  reg [NLED-1:0] sense_ff;    // Output sense per LED
  wire acc = psel & penable;
  wire wr = acc & pwrite;
  wire [7:0] idx = paddr[9:2];  // Word index of the access
  wire hit = (idx == `LDRD_IDX_DUTY) | (idx == `LDRD_IDX_RAMP) |
    (idx == `LDRD_IDX_DELAY) | (idx == `LDRD_IDX_MODE) |
    (idx == `LDRD_IDX_SENSE) | (idx == `LDRD_IDX_STATUS);
  wire bad = (paddr[31:10] != 22'h0) | (paddr[1:0] != 2'h0) | ~hit;  // Unmapped or misaligned
  assign pready = 1'b1;  // Zero wait states
  assign pslverr = acc & bad;
  wire [2:0] release_hold_select = delay_ff[`LDRD_DLY_HI:`LDRD_DLY_LO];
  wire [3:0] direct_peak_duty = duty_ff[`LDRD_PEAK_HI:`LDRD_PEAK_LO];
  wire [3:0] direct_floor_duty = duty_ff[`LDRD_FLOOR_HI:`LDRD_FLOOR_LO];
  wire [NLED-1:0] led_output_sense = sense_ff;
  wire [NLED-1:0] active;
  wire [NLED-1:0] nxt_drive;  // Drive level before the output flop
  reg [31:0] nxt_rdata;       // Read word chosen from the index

  // Writes land only on the access cycle, unmapped ignored
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      duty_ff <= `LDRD_RST_DUTY;
      ramp_ff <= `LDRD_RST_RAMP;
      delay_ff <= 3'h0;
      mode_ff <= {NLED{1'b0}};
      sense_ff <= {NLED{1'b1}};
    end else if (wr && !pslverr) begin
      case (idx)
        `LDRD_IDX_DUTY: duty_ff <= pwdata[7:0];  // R10
        `LDRD_IDX_RAMP: ramp_ff <= {2'h0, pwdata[5:0]};  // R02 R03
        `LDRD_IDX_DELAY: delay_ff <= pwdata[2:0];  // R07
        `LDRD_IDX_MODE: mode_ff <= pwdata[NLED-1:0];
        `LDRD_IDX_SENSE: sense_ff <= pwdata[NLED-1:0];
        default: ;
      endcase
    end
  end

  // Read mux; reserved bits read zero
  always @* begin
    nxt_rdata = 32'h0000_0000;
    case (idx)
      `LDRD_IDX_DUTY: nxt_rdata[7:0] = duty_ff;
      `LDRD_IDX_RAMP: nxt_rdata[7:0] = ramp_ff;
      `LDRD_IDX_DELAY: nxt_rdata[2:0] = delay_ff;
      `LDRD_IDX_MODE: nxt_rdata[NLED-1:0] = mode_ff;
      `LDRD_IDX_SENSE: nxt_rdata[NLED-1:0] = sense_ff;
      `LDRD_IDX_STATUS: nxt_rdata[NLED-1:0] = active;
      default: nxt_rdata = 32'h0000_0000;
    endcase
  end

  // Captured at the end of setup, so the access phase sees a flop
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (psel && !penable)
      prdata <= (pwrite || bad) ? 32'h0000_0000 : nxt_rdata;
  end

  // =====================================================
  // Decode functions
  // Ramp time in ms
  function [11:0] ramp_ms;
    input [2:0] c;
    begin
      case (c)  // R04
        3'h0: ramp_ms = 12'd0;
        3'h1: ramp_ms = 12'd250;
        3'h2: ramp_ms = 12'd500;
        3'h3: ramp_ms = 12'd750;
        3'h4: ramp_ms = 12'd1000;
        3'h5: ramp_ms = 12'd1250;
        3'h6: ramp_ms = 12'd1500;
        default: ramp_ms = 12'd2000;
      endcase
    end
  endfunction
  // Off delay in ms
  function [12:0] hold_ms;
    input [2:0] c;
    begin
      case (c)  // R08
        3'h0: hold_ms = 13'd0;
        3'h1: hold_ms = 13'd500;
        3'h2: hold_ms = 13'd1000;
        3'h3: hold_ms = 13'd1500;
        3'h4: hold_ms = 13'd2000;
        3'h5: hold_ms = 13'd3000;
        3'h6: hold_ms = 13'd4000;
        default: hold_ms = 13'd5000;
      endcase
    end
  endfunction
  // Duty in hundredths of a percent x100 (percent*100)
  function [15:0] duty_pct;
    input [3:0] c;
    input peak;
    reg [6:0] p;
    begin
      p = 7'd0;
      case (c)
        4'h0: p = 7'd7;
        4'h1: p = 7'd9;
        4'h2: p = 7'd11;
        4'h3: p = 7'd14;
        4'h4: p = 7'd17;
        4'h5: p = 7'd20;
        4'h6: p = 7'd23;
        4'h7: p = 7'd26;
        4'h8: p = 7'd30;
        4'h9: p = 7'd35;
        4'ha: p = 7'd40;
        4'hb: p = 7'd46;
        4'hc: p = 7'd53;
        4'hd: p = 7'd63;
        4'he: p = 7'd77;
        default: p = 7'd100;
      endcase
      // Floor table is peak table shifted down one code
      if (!peak)
        p = (c == 4'h0) ? 7'd0 : duty_pct_prev(c);
      duty_pct = {9'h000, p} * 16'd100;
    end
  endfunction
  function [6:0] duty_pct_prev;
    input [3:0] c;
    begin
      case (c)
        4'h1: duty_pct_prev = 7'd7;
        4'h2: duty_pct_prev = 7'd9;
        4'h3: duty_pct_prev = 7'd11;
        4'h4: duty_pct_prev = 7'd14;
        4'h5: duty_pct_prev = 7'd17;
        4'h6: duty_pct_prev = 7'd20;
        4'h7: duty_pct_prev = 7'd23;
        4'h8: duty_pct_prev = 7'd26;
        4'h9: duty_pct_prev = 7'd30;
        4'ha: duty_pct_prev = 7'd35;
        4'hb: duty_pct_prev = 7'd40;
        4'hc: duty_pct_prev = 7'd46;
        4'hd: duty_pct_prev = 7'd53;
        4'he: duty_pct_prev = 7'd63;
        default: duty_pct_prev = 7'd77;
      endcase
    end
  endfunction

  // =====================================================
  // Slow 1 ms tick and PWM frame counter
  reg [31:0] tick_cnt_ff;
  reg [6:0] pwm_ff;  // Position in 100-step PWM frame
  wire tick = (tick_cnt_ff == TICK_CYCLES - 1);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_ff <= 32'h0000_0000;
      pwm_ff <= 7'h00;
    end else begin
      tick_cnt_ff <= tick ? 32'h0000_0000 : tick_cnt_ff + 32'h0000_0001;  // R13
      if (tick_cnt_ff[5:0] == 6'h00)
        pwm_ff <= (pwm_ff == `LDRD_PWM_STEPS - 1) ? 7'h00 : pwm_ff + 7'h01;
    end
  end

  wire [15:0] peak_bp = duty_pct(direct_peak_duty, 1'b1);   // R11
  wire [15:0] floor_bp = duty_pct(direct_floor_duty, 1'b0);  // R11
  wire [11:0] rise_t = ramp_ms(ramp_ff[`LDRD_RISE_HI:`LDRD_RISE_LO]);
  wire [11:0] fall_t = ramp_ms(ramp_ff[`LDRD_FALL_HI:`LDRD_FALL_LO]);
  wire [12:0] hold_t = hold_ms(release_hold_select);
  wire [15:0] pos_bp = pwm_ff * `LDRD_BP_STEP;  // Frame position in hundredths of a percent

  // =====================================================
  // Per-LED sequencer
  genvar g;
  generate
    for (g = 0; g < NLED; g = g + 1) begin : led
      reg [1:0] st_ff;
      reg [12:0] cnt_ff;   // Ms elapsed in the off delay phase
      reg [11:0] lvl_ff;   // Ramp position 0..ramp length in ms scale
      reg falling_ff;
      wire [15:0] span = peak_bp - floor_bp;
      wire [27:0] num = {12'h000, span} * {16'h0000, lvl_ff};
      wire [11:0] len = falling_ff ? fall_t : rise_t;
      wire [27:0] quo = num / {16'h0000, len};
      // Clamp at the peak: a shorter rise code written while holding must not overshoot
      wire [15:0] frac = (len == 12'd0 || lvl_ff >= len) ? (lvl_ff != 12'd0 ? span : 16'd0) : quo[15:0];
      wire [15:0] duty = floor_bp + frac;
      wire on = (pos_bp < duty) | (duty >= `LDRD_DUTY_FULL);
      assign active[g] = (st_ff != `LDRD_ST_IDLE) | falling_ff;
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          st_ff <= `LDRD_ST_IDLE;
          cnt_ff <= 13'h0000;
          lvl_ff <= 12'h000;
          falling_ff <= 1'b0;
        end else if (!mode_ff[g]) begin  // R01
          st_ff <= `LDRD_ST_IDLE;
          lvl_ff <= 12'h000;
          falling_ff <= 1'b0;
        end else begin
          case (st_ff)
            `LDRD_ST_IDLE: begin
              if (led_actuate[g]) begin  // R12
                st_ff <= `LDRD_ST_RISE;
                falling_ff <= 1'b0;
                lvl_ff <= (rise_t == 12'd0) ? 12'd1 : lvl_ff;
              end else if (falling_ff && tick) begin  // R03
                if (lvl_ff <= 12'd1 || fall_t == 12'd0) begin
                  lvl_ff <= 12'h000;
                  falling_ff <= 1'b0;
                end else
                  lvl_ff <= lvl_ff - 12'd1;
              end
            end
            `LDRD_ST_RISE: begin
              if (!led_actuate[g]) begin
                st_ff <= `LDRD_ST_DELAY;
                cnt_ff <= 13'h0000;
              end else if (rise_t == 12'd0 || lvl_ff >= rise_t) begin  // R02
                st_ff <= `LDRD_ST_HOLD;
                lvl_ff <= (rise_t == 12'd0) ? 12'd1 : rise_t;
              end else if (tick)
                lvl_ff <= lvl_ff + 12'd1;
            end
            `LDRD_ST_HOLD: begin
              if (!led_actuate[g]) begin  // R06
                st_ff <= `LDRD_ST_DELAY;
                cnt_ff <= 13'h0000;
              end
            end
            default: begin
              if (led_actuate[g])
                st_ff <= `LDRD_ST_RISE;  // R12
              else if (cnt_ff >= hold_t) begin  // R06
                st_ff <= `LDRD_ST_IDLE;
                falling_ff <= 1'b1;
                lvl_ff <= (fall_t == 12'd0) ? 12'd0 : fall_t;
              end else if (tick)
                cnt_ff <= cnt_ff + 13'd1;
            end
          endcase
        end
      end
      // Output sense: 1 drives high when on
      assign nxt_drive[g] = (mode_ff[g] & on) ~^ led_output_sense[g];  // R09
    end
  endgenerate

  // One register for all drive pins keeps a single driver
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      led_drive <= {NLED{1'b0}};
    else
      led_drive <= nxt_drive;
  end
endmodule
`default_nettype wire

// ---- ldrd_led_load.sv ----
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// LED load: counts lit clocks in a window
module ldrd_led_load (
  input wire logic pclk,
  input wire logic lit,
  input wire logic arm,
  output logic [15:0] lit_cnt
);
  // Arm clears, then every lit clock counts
  always @(posedge pclk) begin
    if (arm) begin
      lit_cnt <= 16'h0000;
    end else if (lit) begin
      lit_cnt <= lit_cnt + 16'h0001;
    end
  end
endmodule
`default_nettype wire

// ---- ldrd_chk_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "ldrd_regs.vh"
// ==========================================
// Port checker for the Direct LED block
module ldrd_chk #(
  parameter NLED = 11,
  parameter TICK_CYCLES = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [NLED-1:0] led_actuate,
  input wire logic [NLED-1:0] led_drive
);
  logic [7:0] duty_ff, ramp_ff, dly_ff; // Shadow settings
  logic [NLED-1:0] mode_ff, sense_ff;
  logic [1:0] wq_ff; // Recent writes, outputs may lag
  logic [7:0] act_ff; // LED0 time held actuated
  wire logic acc = psel & penable & pready;
  wire logic wr = acc & pwrite;
  wire logic hit = paddr == `LDRD_ADDR_DUTY || paddr == `LDRD_ADDR_RAMP || paddr == `LDRD_ADDR_DELAY
    || paddr == `LDRD_ADDR_MODE || paddr == `LDRD_ADDR_SENSE || paddr == `LDRD_ADDR_STATUS;
  // Follow settings as the bus writes them
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      duty_ff <= `LDRD_RST_DUTY;
      ramp_ff <= 8'h00;
      dly_ff <= 8'h00;
      mode_ff <= '0;
      sense_ff <= '1;
      wq_ff <= 2'h0;
      act_ff <= 8'h00;
    end else begin
      if (wr && paddr == `LDRD_ADDR_DUTY) duty_ff <= pwdata[7:0];
      if (wr && paddr == `LDRD_ADDR_RAMP) ramp_ff <= pwdata[7:0];
      if (wr && paddr == `LDRD_ADDR_DELAY) dly_ff <= pwdata[7:0];
      if (wr && paddr == `LDRD_ADDR_MODE) mode_ff <= pwdata[NLED-1:0];
      if (wr && paddr == `LDRD_ADDR_SENSE) sense_ff <= pwdata[NLED-1:0];
      wq_ff <= {wq_ff[0], wr};
      act_ff <= !led_actuate[0] ? 8'h00 : (act_ff == 8'hff ? act_ff : act_ff + 8'h01);
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  chk_zero_wait: assert property (psel && penable |-> pready)
    else $error("pready low in access phase");
  chk_addr_err: assert property (acc |-> pslverr == !hit)
    else $error("pslverr disagrees with map");
  chk_rise_fall_rd: assert property (acc && !pwrite && paddr == `LDRD_ADDR_RAMP |-> prdata[5:0] == ramp_ff[5:0])
    else $error("ramp field readback wrong");
  chk_delay_rd: assert property (acc && !pwrite && paddr == `LDRD_ADDR_DELAY |-> prdata[2:0] == dly_ff[2:0])
    else $error("off delay readback wrong");
  // Non-Direct LEDs sit idle at the inverse of their sense bit
  chk_non_direct: assert property (wq_ff == 2'h0 |-> ((led_drive ^ ~sense_ff) & ~mode_ff) == '0)
    else $error("non-Direct LED not idle");
  chk_delay_hold: assert property ($fell(led_actuate[0]) && mode_ff[0] && sense_ff[0] && act_ff > 8'd40
    && ramp_ff[5:3] == 3'h0 && dly_ff[2:0] != 3'h0 && duty_ff[7:4] == 4'hf |-> led_drive[0] [*8])
    else $error("LED dropped during off delay");
  chk_instant_on: assert property ($rose(led_actuate[0]) && mode_ff[0] && sense_ff[0]
    && ramp_ff[5:3] == 3'h0 && duty_ff[7:4] == 4'hf |-> ##[1:16] led_drive[0])
    else $error("instant rise not seen");
  chk_instant_off: assert property ($fell(led_actuate[0]) && mode_ff[0] && sense_ff[0] && dly_ff[2:0] == 3'h0
    && ramp_ff[2:0] == 3'h0 && duty_ff[3:0] == 4'h0 |-> ##[1:16] !led_drive[0] [*8])
    else $error("instant fall not seen");
  cover property (wr && paddr == `LDRD_ADDR_RAMP);
  cover property ($fell(led_actuate[0]) && mode_ff[0] && dly_ff[2:0] != 3'h0);
  cover property (acc && !hit);
endmodule
bind ldrd_top ldrd_chk #(.NLED(NLED), .TICK_CYCLES(TICK_CYCLES)) u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .led_actuate(led_actuate), .led_drive(led_drive));
`default_nettype wire

// ---- ldrd_top_test.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "ldrd_regs.vh"
// ==========================================
// Bench: 4-clock tick so each ms is 4 clocks
module ldrd_top_test;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err;
  logic [10:0] act = 11'h000;
  logic [10:0] led_drive;
  logic arm = 1'b0;
  logic [15:0] lit_cnt;
  logic [31:0] mdl [int]; // Register model
  int sel = 0; // LED under the load
  int failures = 0;
  int compares = 0;
  int seed = 3;
  int cyc = 0;
  ldrd_top #(.NLED(11), .TICK_CYCLES(4)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .led_actuate(act), .led_drive(led_drive));
  ldrd_led_load u_load (.pclk(pclk), .lit(led_drive[sel]), .arm(arm), .lit_cnt(lit_cnt));
  initial begin
    forever #12.5 pclk = ~pclk;
  end
  // Hang guard, well above the expected run
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      failures++;
      give_verdict();
    end
  end
  task check(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      failures++;
      $display("Error t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // One APB transfer; idle edge first so strobes never clash
  task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [31:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    mdl[a] = d;
  endtask
  task rdc(input logic [31:0] a, input logic [31:0] m);
    apb(1'b0, a, 32'h0);
    check(rd & m, mdl[a] & m);
  endtask
  // Lit clocks over n-1 clocks, compared to a window
  task meas(input int n, input int lo, input int hi);
    int e;
    arm <= 1'b1;
    @(posedge pclk);
    arm <= 1'b0;
    repeat (n) @(posedge pclk);
    e = lit_cnt < lo ? lo : (lit_cnt > hi ? hi : lit_cnt);
    check({16'h0, lit_cnt}, e);
  endtask
  task give_verdict();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    mdl[`LDRD_ADDR_DUTY] = 32'hf0;
    mdl[`LDRD_ADDR_RAMP] = 32'h0;
    mdl[`LDRD_ADDR_DELAY] = 32'h0;
    mdl[`LDRD_ADDR_SENSE] = 32'h7ff;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rdc(`LDRD_ADDR_DUTY, 32'hff);
    rdc(`LDRD_ADDR_SENSE, 32'h7ff);
    for (int i = 0; i < 4; i++) begin
      rdc(`LDRD_ADDR_RAMP, 32'h3f);
      rdc(`LDRD_ADDR_DELAY, 32'h07);
      wr(`LDRD_ADDR_RAMP, $random(seed));
      wr(`LDRD_ADDR_DELAY, $random(seed));
    end
    apb(1'b1, 32'h90, $random(seed));
    apb(1'b0, 32'h90, 32'h0);
    check({rd[31:1], ~err}, 32'h0);
    $display("registers done");
    // LED0 Direct with instant ramps, others random
    wr(`LDRD_ADDR_MODE, 32'h1);
    wr(`LDRD_ADDR_RAMP, 32'h0);
    wr(`LDRD_ADDR_DELAY, 32'h0);
    act <= 11'($random(seed)) | 11'h001;
    meas(6401, 6270, 6400);
    wr(`LDRD_ADDR_DUTY, 32'h00);
    meas(6401, 318, 578);
    act <= 11'h000;
    meas(6401, 0, 130);
    wr(`LDRD_ADDR_SENSE, 32'h7fe);
    meas(6401, 6270, 6400);
    wr(`LDRD_ADDR_SENSE, 32'h7ff);
    $display("instant done");
    // Off delay of 500 ms is 2000 clocks
    wr(`LDRD_ADDR_DUTY, 32'hf0);
    wr(`LDRD_ADDR_DELAY, 32'h1);
    act <= 11'h001;
    repeat (100) @(posedge pclk);
    act <= 11'h000;
    meas(1601, 1500, 1600);
    apb(1'b0, `LDRD_ADDR_STATUS, 32'h0);
    check(rd, 32'h1);
    repeat (800) @(posedge pclk);
    meas(6401, 0, 130);
    $display("delay done");
    // 2 s rise is 8000 clocks; fall 250 ms copied into rise
    wr(`LDRD_ADDR_DELAY, 32'h0);
    wr(`LDRD_ADDR_RAMP, 32'h38);
    act <= 11'h001;
    meas(6401, 2000, 3100);
    repeat (2000) @(posedge pclk);
    wr(`LDRD_ADDR_RAMP, 32'h09);
    act <= 11'h000;
    meas(6401, 300, 750);
    sel = 1;
    act <= 11'h7ff;
    meas(6401, 0, 0);
    $display("ramp done");
    give_verdict();
  end
endmodule
`default_nettype wire
